// ===== src/wdt_control.sv
// Windowed watchdog control: AHB-Lite registers, lock, protection and domain transfer.
// What this block does
// - Nonzero window code enables closed window
// - Nonzero period code enables watchdog timeout
// - Window mode uses period as open window
// - Lock makes the control register read-only
// - Lock only set; clear only in debug
// - Fuse with nonzero period sets lock
// - Busy flag covers transfer of control write
// - Lock write needs the unlock sequence
// - Busy flag is read-only, unprotected
// - Status register: lock bit 7, busy 0
// - Control register: window high, period low
// - Control resets from the fuse value
// - Early or missing clear resets system
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module wdt_control #(
  parameter int unsigned TICK_DIV = wdt_pkg::TICK_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] watchdog_fuse_config,
  input wire logic config_change_protect,
  input wire logic debug_mode,
  input wire logic watchdog_clear_instr,
  output logic system_reset_req,
  output logic irq
);
  import wdt_pkg::*;

  // A divider of one leaves the tick pulse no idle cycle around it; the check asks for at least four.
  if (TICK_DIV < 4) begin : g_tick_div_check
    $error("TICK_DIV must be at least 4");
  end

  wdt_cfg_if cfg ();

  logic fuse_done;
  logic [7:0] watchdog_control;
  logic lock;
  logic sync_pending_flag;
  logic [1:0] sync_count;
  logic [31:0] tick_count;
  logic clear_req;
  logic dp_write;
  logic [7:0] dp_index;
  logic addr_ok;
  logic [7:0] a_index;
  logic wr_ctrl;
  logic wr_status;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_enable;
  logic [EV_W-1:0] events;
  logic [7:0] status_value;
  logic [31:0] next_rdata;

  // **********************************************
  // Bus slave
  // **********************************************
  assign a_index = haddr[9:2];
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_index <= 8'h00;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_write <= addr_ok && hwrite;
      dp_index <= a_index;
    end
  end

  assign status_value = {lock, 6'h00, sync_pending_flag};

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (a_index)
      IDX_CONTROL: next_rdata = {24'h00_0000, watchdog_control};
      IDX_STATUS: next_rdata = {24'h00_0000, status_value};
      IDX_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
      IDX_IRQ_ENABLE: next_rdata = {30'h0000_0000, irq_enable};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  assign wr_ctrl = dp_write && (dp_index == IDX_CONTROL);
  assign wr_status = dp_write && (dp_index == IDX_STATUS);

  // **********************************************
  // Control register and lock
  // **********************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_done <= 1'b0;
      watchdog_control <= 8'h00;
      lock <= STATUS_RESET[LOCK_BIT];
    end else if (!fuse_done) begin
      fuse_done <= 1'b1;
      watchdog_control <= watchdog_fuse_config;
      lock <= (watchdog_fuse_config[PERIOD_LSB +: CODE_W] != CODE_OFF);
    end else begin
      if (wr_ctrl && config_change_protect && !lock) begin
        watchdog_control <= hwdata[7:0];
      end
      if (wr_status && config_change_protect) begin
        if (hwdata[LOCK_BIT]) begin
          lock <= 1'b1;
        end else if (debug_mode) begin
          lock <= 1'b0;
        end
      end
    end
  end

  // **********************************************
  // Watchdog tick and domain transfer
  // **********************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_count <= 32'h0000_0000;
      cfg.tick <= 1'b0;
    end else if (tick_count >= TICK_DIV - 1) begin
      tick_count <= 32'h0000_0000;
      cfg.tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h0000_0001;
      cfg.tick <= 1'b0;
    end
  end

  // Busy covers the fuse load and every accepted control write until two ticks pass.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_pending_flag <= 1'b0;
      sync_count <= 2'h0;
      cfg.cfg_update <= 1'b0;
      cfg.window_code <= CODE_OFF;
      cfg.period_code <= CODE_OFF;
    end else begin
      cfg.cfg_update <= 1'b0;
      if (!fuse_done || (wr_ctrl && config_change_protect && !lock)) begin
        sync_pending_flag <= 1'b1;
        sync_count <= 2'h0;
      end else if (sync_pending_flag && cfg.tick) begin
        if (sync_count == 2'(SYNC_TICKS - 1)) begin
          sync_pending_flag <= 1'b0;
          cfg.cfg_update <= 1'b1;
          cfg.window_code <= watchdog_control[WINDOW_LSB +: CODE_W];
          cfg.period_code <= watchdog_control[PERIOD_LSB +: CODE_W];
        end else begin
          sync_count <= sync_count + 2'h1;
        end
      end
    end
  end

  // A clear instruction is held until the next watchdog tick consumes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_req <= 1'b0;
    end else if (watchdog_clear_instr) begin
      clear_req <= 1'b1;
    end else if (cfg.tick) begin
      clear_req <= 1'b0;
    end
  end

  assign cfg.clear_pulse = clear_req && cfg.tick;

  wdt_timer_core u_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg)
  );

  // **********************************************
  // System reset request and interrupts
  // **********************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_reset_req <= 1'b0;
    end else if (cfg.timeout) begin
      system_reset_req <= 1'b1;
    end
  end

  assign events = {cfg.cfg_update, cfg.timeout};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      irq_status <= (irq_status & ~((dp_write && dp_index == IDX_IRQ_CLEAR) ?
                    hwdata[EV_W-1:0] : '0)) | events;
      if (dp_write && dp_index == IDX_IRQ_ENABLE) begin
        irq_enable <= hwdata[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // **********************************************
  // Checks
  // **********************************************
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Checks of the lock and of the protection key.
  a_lock_holds_ctrl: assert property (lock && fuse_done |=> $stable(watchdog_control))
    else $error("control changed while locked");
  a_lock_no_clear: assert property (fuse_done && lock && !debug_mode |=> lock)
    else $error("lock cleared outside debug");
  a_lock_set: assert property (fuse_done && wr_status && config_change_protect &&
    hwdata[LOCK_BIT] |=> lock)
    else $error("lock not set by protected write");
  a_lock_debug: assert property (fuse_done && wr_status && config_change_protect &&
    !hwdata[LOCK_BIT] && debug_mode |=> !lock)
    else $error("lock not cleared in debug");
  a_lock_needs_key: assert property (fuse_done && !config_change_protect |=>
    $stable(lock))
    else $error("lock changed without unlock");
  a_ctrl_needs_key: assert property (fuse_done && wr_ctrl && !config_change_protect |=>
    $stable(watchdog_control))
    else $error("control changed without unlock");
  // The fuse checks start at the first edge with reset off, when the load happens.
  a_fuse_lock: assert property (hresetn && !fuse_done |=>
    lock == ($past(watchdog_fuse_config[PERIOD_LSB +: CODE_W]) != CODE_OFF))
    else $error("fuse lock not taken");
  a_fuse_ctrl: assert property (hresetn && !fuse_done |=>
    watchdog_control == $past(watchdog_fuse_config))
    else $error("control not loaded from fuse");
  // Checks of the transfer into the watchdog domain.
  a_busy_on_write: assert property (wr_ctrl && config_change_protect &&
    !lock && fuse_done |=> sync_pending_flag)
    else $error("busy not raised on write");
  a_busy_only_write: assert property (fuse_done && !sync_pending_flag &&
    !(wr_ctrl && config_change_protect && !lock) |=> !sync_pending_flag)
    else $error("busy raised without a control write");
  a_busy_clears: assert property ($fell(sync_pending_flag) |-> cfg.cfg_update &&
    cfg.period_code == watchdog_control[PERIOD_LSB +: CODE_W])
    else $error("busy cleared without transfer");
  a_tick_single: assert property (cfg.tick |=> !cfg.tick)
    else $error("watchdog tick longer than one cycle");
  // Checks of the register reads and writes.
  a_status_read: assert property (addr_ok && !hwrite && a_index == IDX_STATUS |=>
    hrdata[7:0] == {$past(lock), 6'h00, $past(sync_pending_flag)})
    else $error("status read wrong");
  a_ctrl_read: assert property (addr_ok && !hwrite && a_index == IDX_CONTROL |=>
    hrdata[7:0] == $past(watchdog_control))
    else $error("control read wrong");
  a_ctrl_write: assert property (wr_ctrl && config_change_protect && !lock &&
    fuse_done |=> watchdog_control == $past(hwdata[7:0]))
    else $error("control write not stored");
  // Checks of the reset request and the interrupt.
  a_reset_req: assert property (cfg.timeout |=> system_reset_req)
    else $error("timeout did not request reset");
  a_reset_sticky: assert property (system_reset_req |=> system_reset_req)
    else $error("reset request dropped");
  a_irq_level: assert property (|(irq_status & irq_enable) |=> irq)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (!(|(irq_status & irq_enable)) |=> !irq)
    else $error("interrupt raised without enabled event");
  a_irq_clear: assert property (dp_write && dp_index == IDX_IRQ_CLEAR &&
    hwdata[EV_SYNC_DONE] && !cfg.cfg_update |=> !irq_status[EV_SYNC_DONE])
    else $error("sync event not cleared");

  c_ctrl_written: cover property (wr_ctrl && config_change_protect && !lock);
  c_sync_done: cover property ($fell(sync_pending_flag));
  c_timeout: cover property (cfg.timeout);
  c_lock_cleared: cover property ($fell(lock));
endmodule : wdt_control

// ===== src/wdt_pkg.sv
// Constants, register map and types of the windowed watchdog control block.
package wdt_pkg;
  // **********************************************
  // Timing
  // **********************************************
  localparam int unsigned HCLK_HZ = 125_000_000;
  localparam int unsigned WDT_CLK_HZ = 1024;
  localparam int unsigned TICK_DIV = HCLK_HZ / WDT_CLK_HZ;
  localparam int unsigned SYNC_TICKS = 2;
  localparam int unsigned CNT_W = 14;
  // **********************************************
  // Register indices; byte address is four times the index
  // **********************************************
  localparam logic [7:0] IDX_CONTROL = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h02;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h03;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h04;
  // **********************************************
  // Fields
  // **********************************************
  localparam int unsigned WINDOW_LSB = 4;
  localparam int unsigned PERIOD_LSB = 0;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned LOCK_BIT = 7;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned EV_TIMEOUT = 0;
  localparam int unsigned EV_SYNC_DONE = 1;
  localparam int unsigned EV_W = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hb;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {ST_OFF, ST_NORMAL, ST_CLOSED, ST_OPEN} wdt_state_e;
endpackage : wdt_pkg

// ===== src/wdt_cfg_if.sv
// Link between the register side and the watchdog timer core.
`timescale 1ns/10ps
interface wdt_cfg_if;
  import wdt_pkg::*;
  logic [3:0] window_code;
  logic [3:0] period_code;
  logic tick;
  logic clear_pulse;
  logic cfg_update;
  logic timeout;
  modport ctrl (output window_code, period_code, tick, clear_pulse, cfg_update, input timeout);
  modport core (input window_code, period_code, tick, clear_pulse, cfg_update, output timeout);
endinterface : wdt_cfg_if

// ===== src/wdt_timer_core.sv
// Timeout counter and window state machine running on watchdog ticks.
`timescale 1ns/10ps
module wdt_timer_core (
  input wire logic hclk,
  input wire logic hresetn,
  wdt_cfg_if.core cfg
);
  import wdt_pkg::*;

  wdt_state_e state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] window_len;
  logic [CNT_W-1:0] period_len;

  // Code n selects 2^(n+2) ticks; reserved codes fall back to the longest span.
  function automatic logic [CNT_W-1:0] span(input logic [3:0] code);
    logic [CNT_W-1:0] s;
    s = {{(CNT_W-1){1'b0}}, 1'b1};
    if (code > CODE_MAX) begin
      s = s << (CODE_MAX + 4'h2);
    end else begin
      s = s << (code + 4'h2);
    end
    return s;
  endfunction : span

  assign window_len = span(cfg.window_code);
  assign period_len = span(cfg.period_code);

  // **********************************************
  // Window state machine
  // **********************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_OFF;
      count <= '0;
      cfg.timeout <= 1'b0;
    end else begin
      cfg.timeout <= 1'b0;
      if (cfg.cfg_update) begin
        count <= '0;
        // A fresh window setting starts with an open period until the first clear.
        state <= (cfg.period_code == CODE_OFF) ? ST_OFF : ST_NORMAL;
      end else if (cfg.tick) begin
        unique case (state)
          ST_OFF: begin
            count <= '0;
          end
          ST_NORMAL, ST_OPEN: begin
            if (cfg.clear_pulse) begin
              count <= '0;
              state <= (cfg.window_code != CODE_OFF) ? ST_CLOSED : ST_NORMAL;
            end else if (count + 1'b1 >= period_len) begin
              cfg.timeout <= 1'b1;
              count <= '0;
            end else begin
              count <= count + 1'b1;
            end
          end
          ST_CLOSED: begin
            if (cfg.clear_pulse) begin
              cfg.timeout <= 1'b1;
              count <= '0;
            end else if (count + 1'b1 >= window_len) begin
              count <= '0;
              state <= ST_OPEN;
            end else begin
              count <= count + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // **********************************************
  // Checks
  // **********************************************
  a_closed_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_CLOSED && cfg.tick && cfg.clear_pulse && !cfg.cfg_update)
    |=> cfg.timeout)
    else $error("clear in closed window did not time out");
  a_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_OFF) |=> !cfg.timeout)
    else $error("timeout while watchdog off");
  c_open_reached: cover property (@(posedge hclk) disable iff (!hresetn)
    state == ST_CLOSED ##1 state == ST_OPEN);
endmodule : wdt_timer_core

// ===== testbench/tb_top.sv
// Self-checking testbench of the windowed watchdog control block.
`timescale 1ns/10ps
module tb_top;
  import wdt_pkg::*;
  localparam int unsigned TDIV = 8;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] fuse, code, exp_ctrl;
  logic protect, debug, clr, sysrst;
  int error_cnt, checks;
  integer seed;
  assign hready = hreadyout;
  wdt_control #(.TICK_DIV(TDIV)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .watchdog_fuse_config(fuse), .config_change_protect(protect), .debug_mode(debug),
    .watchdog_clear_instr(clr), .system_reset_req(sysrst), .irq(irq));
  always #4 hclk = ~hclk;
  // **********************************************
  // Expectations, comparisons and bus cycles
  // **********************************************
  function automatic logic [31:0] status_word(input logic lock, input logic busy);
    return {24'h0, lock, 6'h0, busy};
  endfunction : status_word
  function automatic int span(input int ticks);
    return ticks * TDIV;
  endfunction : span
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr_en;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr_en ? wd : 32'h0;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_bit("bus_response_okay", 1'b0, hresp);
  endtask : bus
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      bus(1'b0, IDX_STATUS, 32'h0);
      k++;
    end while (rd[BUSY_BIT] !== 1'b0 && k < 40);
    chk_bit("busy_cleared", 1'b0, rd[BUSY_BIT]);
  endtask : wait_idle
  task automatic do_reset(input logic [7:0] f);
    hresetn <= 1'b0;
    fuse <= f;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  task automatic pulse_clear(input int gap);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (gap) @(posedge hclk);
  endtask : pulse_clear
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // **********************************************
  // Scenarios
  // **********************************************
  initial begin
    #(8 * 30000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fuse = 8'h0;
    protect = 1'b0;
    debug = 1'b0;
    clr = 1'b0;
    error_cnt = 0;
    checks = 0;
    seed = 28;
    do_reset(8'h35);
    rdchk("control_from_fuse", IDX_CONTROL, 32'h35);
    rdchk("status_fuse_lock", IDX_STATUS, status_word(1'b1, 1'b1));
    wait_idle();
    protect <= 1'b1;
    bus(1'b1, IDX_CONTROL, 32'h12);
    rdchk("control_locked", IDX_CONTROL, 32'h35);
    bus(1'b1, IDX_STATUS, 32'h0);
    rdchk("lock_kept", IDX_STATUS, status_word(1'b1, 1'b0));
    debug <= 1'b1;
    bus(1'b1, IDX_STATUS, 32'h0);
    rdchk("lock_cleared_debug", IDX_STATUS, status_word(1'b0, 1'b0));
    debug <= 1'b0;
    protect <= 1'b0;
    do_reset(8'h00);
    rdchk("status_after_reset", IDX_STATUS, status_word(1'b0, 1'b1));
    wait_idle();
    bus(1'b1, IDX_CONTROL, 32'h56);
    rdchk("control_unprotected", IDX_CONTROL, 32'h0);
    bus(1'b1, IDX_STATUS, 32'h81);
    rdchk("lock_unprotected", IDX_STATUS, status_word(1'b0, 1'b0));
    bus(1'b1, 8'h3f, 32'hff);
    rdchk("unmapped_read", 8'h3f, 32'h0);
    exp_ctrl = 8'h00;
    for (int i = 0; i < 12; i++) begin
      code[7:4] = 4'($unsigned($random(seed)) % 12);
      code[3:0] = 4'($unsigned($random(seed)) % 12);
      protect <= 1'($random(seed));
      @(posedge hclk);
      bus(1'b1, IDX_CONTROL, {24'h0, code});
      rdchk("status_busy", IDX_STATUS, status_word(1'b0, protect));
      exp_ctrl = protect ? code : exp_ctrl;
      rdchk("control_fields", IDX_CONTROL, {24'h0, exp_ctrl});
      wait_idle();
    end
    protect <= 1'b1;
    bus(1'b1, IDX_CONTROL, 32'hcc);
    exp_ctrl = 8'hcc;
    rdchk("reserved_code_kept", IDX_CONTROL, {24'h0, exp_ctrl});
    wait_idle();
    bus(1'b0, IDX_IRQ_STATUS, 32'h0);
    chk_bit("sync_done_event", 1'b1, rd[EV_SYNC_DONE]);
    chk_bit("irq_masked", 1'b0, irq);
    bus(1'b1, IDX_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge hclk);
    chk_bit("irq_enabled", 1'b1, irq);
    rdchk("irq_clear_reads_zero", IDX_IRQ_CLEAR, 32'h0);
    bus(1'b1, IDX_IRQ_CLEAR, 32'h2);
    repeat (2) @(posedge hclk);
    chk_bit("irq_cleared", 1'b0, irq);
    rdchk("irq_enable_kept", IDX_IRQ_ENABLE, 32'h2);
    protect <= 1'b1;
    bus(1'b1, IDX_STATUS, 32'h80);
    rdchk("lock_set", IDX_STATUS, status_word(1'b1, 1'b0));
    bus(1'b1, IDX_CONTROL, 32'h22);
    rdchk("control_after_lock", IDX_CONTROL, {24'h0, exp_ctrl});
    do_reset(8'h00);
    wait_idle();
    bus(1'b1, IDX_CONTROL, 32'h01);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      pulse_clear(span(4));
    end
    chk_bit("no_timeout_with_clears", 1'b0, sysrst);
    repeat (span(12)) @(posedge hclk);
    chk_bit("normal_timeout", 1'b1, sysrst);
    rdchk("timeout_event", IDX_IRQ_STATUS, 32'h3);
    do_reset(8'h00);
    wait_idle();
    bus(1'b1, IDX_CONTROL, 32'h11);
    wait_idle();
    pulse_clear(span(10));
    chk_bit("closed_window_open", 1'b0, sysrst);
    pulse_clear(span(2));
    chk_bit("clear_in_open_window", 1'b0, sysrst);
    pulse_clear(span(3));
    chk_bit("early_clear_reset", 1'b1, sysrst);
    tally_and_finish();
  end
endmodule : tb_top
